/* jtisp_port.sv */
// Test access port with bypass, identification and row programming.
// Assumes test pins arrive on the test clock; core side is i_core_clk.
module jtisp_port
   import jtisp_pkg::*;
(
   input wire logic i_core_clk,             // Core clock
   input wire logic i_reset,                // Power-up reset, sync high
   input wire logic i_tck,                  // Test clock
   input wire logic i_tms,                  // Mode select
   input wire logic i_tdi,                  // Serial data in
   output logic o_tdo,                      // Serial data out
   output logic o_tdo_oe,                   // Serial out drive enable
   input wire logic i_port_disable,         // Configuration turns port off
   output logic o_pins_user_io,             // Pins released to user I/O
   output logic o_prog_enabled,             // Programming unlocked
   output logic [ROWS-1:0] o_row_written    // Row changed since reset
);

   // ******************************************************
   // Reset crossing into the test domain
   // ******************************************************
   // No test reset pin exists; the core reset is carried over by two flops.
   // The crossing only moves while the test clock runs, so the controller
   // must give a few clocks during reset for the port to clear.
   logic rst_meta;
   logic rst_tck;

   always_ff @(posedge i_tck) begin
      rst_meta <= i_reset;
      rst_tck <= rst_meta;
   end

   // Port enable is a configuration level sampled in the core domain
   // It is a slow level, so a single core flop registers it
   logic port_off;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         port_off <= 1'b0;
      end else begin
         port_off <= i_port_disable;
      end
   end

   assign o_pins_user_io = port_off;

   // A single level bit, so two flops are enough to bring it across
   logic off_meta;
   logic off_tck;

   always_ff @(posedge i_tck) begin
      off_meta <= port_off;
      off_tck <= off_meta;
   end

   wire tap_hold = rst_tck | off_tck;

   // ******************************************************
   // Controller state machine
   // ******************************************************
   // Five clocks with mode select high reach reset from any state
   jtisp_tap_t state;
   jtisp_tap_t next_state;

   always_comb begin
      case (state)
         TAP_RESET: next_state = i_tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_state = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_state = i_tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: next_state = i_tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: next_state = i_tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: next_state = i_tms ? TAP_EX2_DR : TAP_PAUSE_DR;
         TAP_EX2_DR: next_state = i_tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_state = i_tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: next_state = i_tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: next_state = i_tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: next_state = i_tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: next_state = i_tms ? TAP_EX2_IR : TAP_PAUSE_IR;
         TAP_EX2_IR: next_state = i_tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: next_state = i_tms ? TAP_SEL_DR : TAP_IDLE;
         default: next_state = TAP_RESET;
      endcase
   end

   // With mode select held high the controller parks in reset (user mode)
   // Reset or a disabled port parks it there as well
   always_ff @(posedge i_tck) begin
      if (tap_hold) begin
         state <= TAP_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ******************************************************
   // Instruction register
   // ******************************************************
   // The shift stage keeps the live instruction stable while a new one
   // is scanned in; it only takes effect at update.
   logic [3:0] ir_shift;
   logic [3:0] ir;

   always_ff @(posedge i_tck) begin
      if (tap_hold) begin
         ir_shift <= IR_RESET_VALUE;
      end else if (state == TAP_CAP_IR) begin
         ir_shift <= IR_CAPTURE_VALUE;
      end else if (state == TAP_SH_IR) begin
         ir_shift <= {i_tdi, ir_shift[3:1]};
      end
   end

   // Reset value selects identification, as a blind probe expects
   always_ff @(posedge i_tck) begin
      if (tap_hold || state == TAP_RESET) begin
         ir <= IR_RESET_VALUE;
      end else if (state == TAP_UPD_IR) begin
         ir <= ir_shift;
      end
   end

   // Programming commands share the row shift register
   function automatic logic is_prog_cmd(input logic [3:0] code);
      return code == INSTR_PROG_ENABLE || code == INSTR_ERASE ||
         code == INSTR_WRITE_ROW || code == INSTR_READ_ROW;
   endfunction

   // Anything left undecoded falls through to bypass
   wire sel_id = (ir == INSTR_IDCODE);
   wire sel_prog = is_prog_cmd(ir);
   wire sel_byp = !sel_id && !sel_prog;

   // ******************************************************
   // Data registers
   // ******************************************************
   logic bypass_bit;
   logic [31:0] id_shift;
   logic [PROG_SR_W-1:0] prog_shift;
   logic [ROW_DATA_W-1:0] cfg_array [ROWS];
   logic prog_unlock;

   wire [ROW_ADDR_W-1:0] row_addr = prog_shift[PROG_SR_W-1 -: ROW_ADDR_W];

   // Bypass captures zero, so a chain probe can count the stages
   // by the leading zeros it sees.
   always_ff @(posedge i_tck) begin
      if (state == TAP_CAP_DR) begin
         bypass_bit <= 1'b0;
      end else if (state == TAP_SH_DR) begin
         bypass_bit <= i_tdi;
      end
   end

   // Loaded on every capture; only the selection decides if it is seen
   always_ff @(posedge i_tck) begin
      if (state == TAP_CAP_DR) begin
         id_shift <= ID_VALUE;
      end else if (state == TAP_SH_DR) begin
         id_shift <= {i_tdi, id_shift[31:1]};
      end
   end

   // Read-back loads the addressed row, keeping the address field
   // Without enable the shift register keeps what it last held
   always_ff @(posedge i_tck) begin
      if (tap_hold) begin
         prog_shift <= '0;
      end else if (state == TAP_CAP_DR && ir == INSTR_READ_ROW &&
                   prog_unlock) begin
         prog_shift[ROW_DATA_W-1:0] <= cfg_array[row_addr];
      end else if (state == TAP_SH_DR && sel_prog) begin
         prog_shift <= {i_tdi, prog_shift[PROG_SR_W-1:1]};
      end
   end

   // Enable stays in force across later programming commands
   // Any other instruction, or reset, locks the array again
   always_ff @(posedge i_tck) begin
      if (tap_hold || state == TAP_RESET) begin
         prog_unlock <= 1'b0;
      end else if (state == TAP_UPD_IR) begin
         if (ir_shift == INSTR_PROG_ENABLE) begin
            prog_unlock <= 1'b1;
         end else if (!is_prog_cmd(ir_shift)) begin
            prog_unlock <= 1'b0;
         end
      end
   end

   // Erase and write act only at update, once the whole word has arrived
   // Array cells change only through the serial port, no extra supply
   wire do_erase = state == TAP_UPD_DR && ir == INSTR_ERASE && prog_unlock;
   wire do_write = state == TAP_UPD_DR && ir == INSTR_WRITE_ROW &&
                   prog_unlock;

   // Array contents survive reset like nonvolatile cells; blank is all ones
   logic [ROWS-1:0] row_written;
   generate
      for (genvar r = 0; r < ROWS; r++) begin : g_row
         always_ff @(posedge i_tck) begin
            if (do_erase) begin
               cfg_array[r] <= ERASED_ROW;
            end else if (do_write && row_addr == ROW_ADDR_W'(r)) begin
               cfg_array[r] <= prog_shift[ROW_DATA_W-1:0];
            end
         end

         always_ff @(posedge i_tck) begin
            if (rst_tck) begin
               row_written[r] <= 1'b0;
            end else if (do_erase ||
                         (do_write && row_addr == ROW_ADDR_W'(r))) begin
               row_written[r] <= 1'b1;
            end
         end
      end
   endgenerate

   // ******************************************************
   // Serial output, falling edge
   // ******************************************************
   // Instruction shift wins; otherwise the live instruction picks the path
   logic tdo_bit;

   always_comb begin
      if (state == TAP_SH_IR) begin
         tdo_bit = ir_shift[0];
      end else if (sel_id) begin
         tdo_bit = id_shift[0];
      end else if (sel_prog) begin
         tdo_bit = prog_shift[0];
      end else begin
         tdo_bit = bypass_bit & sel_byp;
      end
   end

   // Registered on the falling edge: the far side gets half a period of
   // setup before it samples on its next rising edge.
   // Driver enable follows shift states only; tri-state otherwise
   logic tdo_q;
   logic tdo_en;

   always_ff @(negedge i_tck) begin
      tdo_q <= tdo_bit;
      tdo_en <= !tap_hold &&
                (state == TAP_SH_DR || state == TAP_SH_IR);
   end

   assign o_tdo = tdo_q;
   assign o_tdo_oe = tdo_en;

   // ******************************************************
   // Status into the core domain
   // ******************************************************
   // Buried logic behind the pins is unaffected: this port never owns it.
   // The word is only taken once two synchronised samples in a row agree,
   // so a word caught while its bits are changing is never shown.
   // Status changes seldom, so the two extra cycles of latency cost nothing.
   // Limitation: a change faster than two core clocks may be missed.
   logic [ROWS:0] st_meta;
   logic [ROWS:0] st_sync;
   logic [ROWS:0] st_prev;
   logic [ROWS:0] st_core;

   always_ff @(posedge i_core_clk) begin
      st_meta <= {prog_unlock, row_written};
      st_sync <= st_meta;
      st_prev <= st_sync;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_core <= '0;
      end else if (st_sync == st_prev) begin
         st_core <= st_prev;
      end
   end

   assign o_prog_enabled = i_reset ? 1'b0 : st_core[ROWS];
   assign o_row_written = i_reset ? '0 : st_core[ROWS-1:0];

endmodule

/* jtisp_pkg.sv */
// Package for the test access and in-circuit reprogramming port.
// Assumes one core clock domain and one test clock domain driven from pins.
package jtisp_pkg;

   // ******************************************************
   // Instruction codes
   // ******************************************************
   localparam logic [3:0] INSTR_IDCODE = 4'h1;
   localparam logic [3:0] INSTR_PROG_ENABLE = 4'h9;
   localparam logic [3:0] INSTR_ERASE = 4'hA;
   localparam logic [3:0] INSTR_WRITE_ROW = 4'hB;
   localparam logic [3:0] INSTR_READ_ROW = 4'hC;
   localparam logic [3:0] INSTR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
   localparam logic [3:0] IR_RESET_VALUE = 4'h1;

   // ******************************************************
   // Array geometry and identity
   // ******************************************************
   localparam int ROW_ADDR_W = 4;
   localparam int ROW_DATA_W = 16;
   localparam int ROWS = 16;
   localparam int PROG_SR_W = ROW_ADDR_W + ROW_DATA_W;
   // Arbitrary identification value, not tied to any maker
   localparam logic [31:0] ID_VALUE = 32'h1234_5001;
   localparam logic [ROW_DATA_W-1:0] ERASED_ROW = 16'hFFFF;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
   } jtisp_tap_t;

endpackage

/* jtisp_port_checker.sv */
// Assertions on the ports of the test port.
// Assumes the core reset also clears the test clock logic.
module jtisp_port_checker
   import jtisp_pkg::*;
(
   input wire logic i_core_clk, // Core clock
   input wire logic i_reset, // Reset
   input wire logic i_tck, // Test clock
   input wire logic i_tms, // Mode select
   input wire logic o_tdo_oe, // Drive enable
   input wire logic i_port_disable, // Port off
   input wire logic o_pins_user_io, // User I/O
   input wire logic o_prog_enabled, // Unlocked
   input wire logic [ROWS-1:0] o_row_written // Rows changed
);
   // **********
   // Properties
   // **********
   sequence s_tms_hold;
      i_tms [*5];
   endsequence
   sequence s_shift_exit;
      o_tdo_oe && i_tms;
   endsequence
   AST_TMS_RESET: assert property (
      @(posedge i_tck) disable iff (i_reset)
      s_tms_hold |=> !o_tdo_oe) else $error("tdo driven after tms reset");
   AST_SHIFT_EXIT: assert property (
      @(posedge i_tck) disable iff (i_reset)
      s_shift_exit |=> !o_tdo_oe) else $error("tdo driven after exit");
   AST_NO_ENTRY: assert property (
      @(posedge i_tck) disable iff (i_reset)
      !o_tdo_oe && i_tms |=> !o_tdo_oe) else $error("tdo driven early");
   AST_DIS_OFF: assert property (
      @(posedge i_tck) disable iff (i_reset)
      i_port_disable [*4] |=> !o_tdo_oe)
      else $error("tdo driven when off");
   AST_USER_IO: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      1 |=> o_pins_user_io == $past(i_port_disable))
      else $error("user io does not follow disable");
   AST_RST_CLR: assert property (
      @(posedge i_core_clk)
      i_reset [*4] |-> !o_prog_enabled && o_row_written == 16'h0000)
      else $error("status not cleared by reset");
   AST_ROW_LOCK: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      o_row_written != $past(o_row_written) |-> o_prog_enabled)
      else $error("row changed while locked");
   AST_ROW_KEEP: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      1 |=> ($past(o_row_written) & ~o_row_written) == 16'h0000)
      else $error("row flag dropped");
endmodule
bind jtisp_port jtisp_port_checker jtisp_port_checker_i (.i_core_clk,
   .i_reset, .i_tck, .i_tms, .o_tdo_oe, .i_port_disable, .o_pins_user_io,
   .o_prog_enabled, .o_row_written);

/* jtisp_ctl.sv */
// External test controller model driving the test pins.
// Assumes a pull-up on the serial output line.
module jtisp_ctl (
   output logic o_tck, // Test clock
   output logic o_tms, // Mode select
   output logic o_tdi, // Serial data
   input wire logic i_tdo, // Serial out
   input wire logic i_tdo_oe // Out enable
);
   timeunit 1ns;
   timeprecision 1ns;
   int slow = 0;
   logic line;
   // Released line reads the pull-up level, never the stale bit
   assign line = i_tdo_oe ? i_tdo : 1'b1;
   initial begin
      o_tck = 0;
      o_tms = 1;
      o_tdi = 1;
   end
   // Clock stands still low between steps
   task automatic step(input logic m, input logic d, output logic q);
      o_tms = m;
      o_tdi = d;
      #(15 + slow);
      q = line;
      o_tck = 1;
      #15;
      o_tck = 0;
   endtask
   task automatic tap_reset();
      logic b;
      repeat (5) step(1, 1, b);
      step(0, 1, b);
   endtask
   task automatic scan(input logic ir, input int n, input logic [31:0] d,
                       output logic [31:0] q);
      logic b;
      q = '0;
      step(1, 1, b);
      if (ir) step(1, 1, b);
      step(0, 1, b);
      step(0, 1, b);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, d[k], b);
         q[k] = b;
      end
      step(1, 1, b);
      step(0, 1, b);
   endtask
endmodule

/* test_jtisp_port.sv */
// Testbench of the test port against the controller model.
// Assumes test and core clocks are unrelated.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   $display("wrong value %s expected %h seen %h", n, e, g); \
   error_cnt++; end end
module test_jtisp_port
   import jtisp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [3:0] c; int n; logic [31:0] d; logic [31:0] e;}
      jtisp_row_t;
   jtisp_row_t rows [4] = '{'{4'h1, 32, 0, ID_VALUE},
      '{4'hF, 8, 32'hA5, 32'h4A}, '{4'h5, 8, 32'h3C, 32'h78},
      '{4'h0, 8, 32'h81, 32'h02}};
   logic i_core_clk = 0;
   logic i_reset = 1;
   logic i_port_disable = 0;
   logic tck, tms, tdi, tdo, tdo_oe, user_io, prog_en;
   logic [15:0] row_wr;
   logic [31:0] q;
   int error_cnt = 0;
   int check_count = 0;
   jtisp_port jtisp_port_i (.i_core_clk(i_core_clk), .i_reset(i_reset),
      .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
      .i_port_disable(i_port_disable), .o_pins_user_io(user_io),
      .o_prog_enabled(prog_en), .o_row_written(row_wr));
   jtisp_ctl jtisp_ctl_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .i_tdo(tdo), .i_tdo_oe(tdo_oe));
   initial forever #50 i_core_clk = ~i_core_clk;
   // **********
   // Tasks
   // **********
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic core(input int n);
      repeat (n) @(posedge i_core_clk);
      #5;
   endtask
   task automatic ir(input logic [3:0] c);
      jtisp_ctl_i.scan(1, 4, {28'h0, c}, q);
      `CHK("ir capture", 32'h1, q)
   endtask
   task automatic dr(input int n, input logic [31:0] d, input logic [31:0] e);
      jtisp_ctl_i.scan(0, n, d, q);
      `CHK("dr out", e, q)
   endtask
   task automatic do_reset();
      core(1);
      i_reset = 1;
      fork
         jtisp_ctl_i.tap_reset();
         core(8);
      join
      i_reset = 0;
      jtisp_ctl_i.tap_reset();
   endtask
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end
   // **********
   // Sequence
   // **********
   initial begin
      do_reset();
      dr(32, 0, ID_VALUE);
      foreach (rows[k]) begin
         ir(rows[k].c);
         dr(rows[k].n, rows[k].d, rows[k].e);
      end
      $display("test table done");
      jtisp_ctl_i.slow = 120;
      ir(4'hB);
      jtisp_ctl_i.scan(0, 20, 32'h31234, q);
      core(4);
      `CHK("locked rows", 16'h0000, row_wr)
      ir(4'h9);
      core(4);
      `CHK("unlock", 1'b1, prog_en)
      ir(4'hB);
      jtisp_ctl_i.scan(0, 20, 32'h5BEEF, q);
      core(4);
      `CHK("row written", 16'h0020, row_wr)
      ir(4'hC);
      dr(20, 32'h50000, 32'h5BEEF);
      ir(4'hA);
      jtisp_ctl_i.scan(0, 20, 32'h50000, q);
      core(4);
      `CHK("erase rows", 16'hFFFF, row_wr)
      ir(4'hC);
      dr(20, 32'h0, 32'h5FFFF);
      ir(4'h1);
      core(4);
      `CHK("relock", 1'b0, prog_en)
      `CHK("idle oe", 1'b0, tdo_oe)
      $display("test programming done");
      i_port_disable = 1;
      core(2);
      `CHK("user io", 1'b1, user_io)
      jtisp_ctl_i.scan(1, 4, 32'h1, q);
      `CHK("off port", 32'hF, q)
      i_port_disable = 0;
      core(2);
      `CHK("port back", 1'b0, user_io)
      $display("test disable done");
      do_reset();
      `CHK("reset rows", 16'h0000, row_wr)
      dr(32, 0, ID_VALUE);
      $display("test reset done");
      close_out();
   end
endmodule
